// file: hdl/cas_cfg.svh
// Constants of the coded character display scanner
`ifndef CAS_CFG_SVH
`define CAS_CFG_SVH

// Clock rates in Hz
`define CAS_MCLK_HZ        250000000
`define CAS_SCAN_HZ_BASE   1000000
`define CAS_SCAN_HZ_LONG   2000000
`define CAS_REFRESH_HZ     100

// Character memory
`define CAS_RAM_WORDS      128
`define CAS_RAM_AW         7
`define CAS_RAM_DW         8
`define CAS_RAM_INIT       8'h20

// Host write queue: address above data
`define CAS_WQ_W           15
`define CAS_WQ_DEPTH       4
`define CAS_WQ_ADDR_MSB    14
`define CAS_WQ_ADDR_LSB    8

// Scan counters
`define CAS_CHAR_W         8
`define CAS_ROW_LAST       3'h7
`define CAS_COL_LAST       3'h4
`define CAS_COLS           5
`define CAS_COL_FIRST      5'h01
`define CAS_ADDR32_LAST    5'h1F

`endif

// file: hdl/cas_pkg.sv
// Types of the coded character display scanner
`include "cas_cfg.svh"
package cas_pkg;

	typedef enum logic [1:0] {
		CAS_M32  = 2'h0,
		CAS_M64  = 2'h1,
		CAS_M128 = 2'h2
	} cas_mode_t;

	typedef logic [`CAS_CHAR_W-1:0] cas_char_t;
	typedef logic [34:0]            cas_glyph_t;

endpackage : cas_pkg

// file: hdl/cas_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps
module cas_fifo #(
	parameter int W = 15,
	parameter int D = 4
) (
	input  wire logic         i_clk,
	input  wire logic         i_reset,
	input  wire logic         i_in_valid,
	output wire logic         o_in_ready,
	input  wire logic [W-1:0] i_in_data,
	output wire logic         o_out_valid,
	input  wire logic         i_out_ready,
	output wire logic [W-1:0] o_out_data
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem_ff [0:D-1];
	logic [AW:0]  wr_ptr_ff;
	logic [AW:0]  rd_ptr_ff;
	logic         full;
	logic         empty;
	logic         push;
	logic         pop;

	assign full        = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
	                     (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
	assign empty       = (wr_ptr_ff == rd_ptr_ff);
	assign o_in_ready  = !full;
	assign o_out_valid = !empty;
	assign o_out_data  = mem_ff[rd_ptr_ff[AW-1:0]];
	assign push        = i_in_valid && !full;
	assign pop         = i_out_ready && !empty;

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff[AW-1:0]] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			wr_ptr_ff <= '0;
		end else if (push) begin
			wr_ptr_ff <= wr_ptr_ff + 1'b1;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			rd_ptr_ff <= '0;
		end else if (pop) begin
			rd_ptr_ff <= rd_ptr_ff + 1'b1;
		end
	end

	fifo_full_a: assert property (@(posedge i_clk) disable iff (i_reset)
		full |-> !o_in_ready ##0 !push)
		else $error("fifo accepted a word while full");

endmodule : cas_fifo

// file: hdl/cas_scanner.sv
// Coded character display scanner with local character memory
//
// Summary of operation
// - Hold codes in 128 by 8 memory.
// - Local logic alone sequences decode, load, columns.
// - Host writes win memory over scan reads.
// - Refresh continues forever without the host.
// - Base mode shows 32 stored codes.
// - Decoder gives five columns; mux picks one.
// - Divide-by-8 row counter selects the row.
// - Seven display clock pulses per character.
// - Eight-bit character counter; low bits address.
// - Top three bits all one: load pass.
// - Other seven super-periods show the column.
// - Column duty factor is 17.5 percent.
// - 64 mode: six address bits, top two load.
// - Scan clock 1 MHz feeds rows and display.
// - 128 mode uses 2 MHz scan clock.
// - Blank and columns off while loading.
// - Rows shift out from row 7 down.
// - Five columns, one per load-display cycle.
`timescale 1ns/100ps
`include "cas_cfg.svh"
module cas_scanner (
	input  wire logic                      i_mclk,
	input  wire logic                      i_reset,
	input  wire logic                      i_lclk,
	input  wire cas_pkg::cas_mode_t        i_mode,
	input  wire logic                      i_wr_valid,
	output wire logic                      o_wr_ready,
	input  wire logic [`CAS_RAM_AW-1:0]    i_wr_addr,
	input  wire logic [`CAS_RAM_DW-1:0]    i_wr_data,
	output wire logic                      o_disp_data,
	output wire logic                      o_disp_clk,
	output wire logic                      o_blank,
	output wire logic [`CAS_COLS-1:0]      o_col_drv
);
	import cas_pkg::*;

	function automatic logic [`CAS_CHAR_W-1:0] gray2bin(
		input logic [`CAS_CHAR_W-1:0] g);
		logic [`CAS_CHAR_W-1:0] b;
		b[`CAS_CHAR_W-1] = g[`CAS_CHAR_W-1];
		for (int k = `CAS_CHAR_W - 2; k >= 0; k--) begin
			b[k] = b[k+1] ^ g[k];
		end
		return b;
	endfunction : gray2bin

	// Character address bits in use for each length option
	function automatic logic [`CAS_RAM_AW-1:0] addr_mask(
		input cas_char_t cnt, input cas_mode_t mode);
		case (mode)
			CAS_M64:  return {1'b0, cnt[5:0]};
			CAS_M128: return cnt[6:0];
			default:  return {2'h0, cnt[4:0]};
		endcase
	endfunction : addr_mask

	// Load pass when the phase bits above the address are all one
	function automatic logic is_load(
		input cas_char_t cnt, input cas_mode_t mode);
		case (mode)
			CAS_M64:  return &cnt[7:6];
			CAS_M128: return cnt[7];
			default:  return &cnt[7:5];
		endcase
	endfunction : is_load

	// Glyph rows 7 down to 1, each five columns, left column in MSB
	function automatic cas_glyph_t glyph(input logic [6:0] code);
		case (code)
			7'h20: return 35'h0;
			7'h2D: return {5'h00,5'h00,5'h00,5'h1F,5'h00,5'h00,5'h00};
			7'h30: return {5'h0E,5'h11,5'h13,5'h15,5'h19,5'h11,5'h0E};
			7'h31: return {5'h04,5'h0C,5'h04,5'h04,5'h04,5'h04,5'h0E};
			7'h32: return {5'h0E,5'h11,5'h01,5'h02,5'h04,5'h08,5'h1F};
			7'h33: return {5'h1F,5'h02,5'h04,5'h02,5'h01,5'h11,5'h0E};
			7'h34: return {5'h02,5'h06,5'h0A,5'h12,5'h1F,5'h02,5'h02};
			7'h35: return {5'h1F,5'h10,5'h1E,5'h01,5'h01,5'h11,5'h0E};
			7'h36: return {5'h06,5'h08,5'h10,5'h1E,5'h11,5'h11,5'h0E};
			7'h37: return {5'h1F,5'h01,5'h02,5'h04,5'h08,5'h08,5'h08};
			7'h38: return {5'h0E,5'h11,5'h11,5'h0E,5'h11,5'h11,5'h0E};
			7'h39: return {5'h0E,5'h11,5'h11,5'h0F,5'h01,5'h02,5'h0C};
			7'h41: return {5'h0E,5'h11,5'h11,5'h1F,5'h11,5'h11,5'h11};
			7'h42: return {5'h1E,5'h11,5'h11,5'h1E,5'h11,5'h11,5'h1E};
			7'h43: return {5'h0E,5'h11,5'h10,5'h10,5'h10,5'h11,5'h0E};
			7'h44: return {5'h1E,5'h11,5'h11,5'h11,5'h11,5'h11,5'h1E};
			7'h45: return {5'h1F,5'h10,5'h10,5'h1E,5'h10,5'h10,5'h1F};
			7'h46: return {5'h1F,5'h10,5'h10,5'h1E,5'h10,5'h10,5'h10};
			default: begin
				// Codes from 7'h20 up without a glyph show a hollow box; codes below 7'h20 are blank
				if (code < 7'h20) begin
					return 35'h0;
				end
				return {5'h1F,5'h11,5'h11,5'h11,5'h11,5'h11,5'h1F};
			end
		endcase
	endfunction : glyph

	// Master clock side: host queue and character memory
	logic [`CAS_WQ_W-1:0]    wq_data;
	logic                    wq_valid;
	logic                    wq_ready;
	logic                    wr_fire;
	logic [`CAS_RAM_DW-1:0]  ram_ff [0:`CAS_RAM_WORDS-1];
	logic [`CAS_RAM_AW-1:0]  wr_addr;
	logic [`CAS_RAM_AW-1:0]  rd_addr;
	logic [`CAS_RAM_DW-1:0]  rd_data_ff;
	logic [`CAS_RAM_DW-1:0]  sent_ff;
	logic                    req_ff;
	logic                    ack_m1_ff;
	logic                    ack_m2_ff;
	cas_char_t               gray_m1_ff;
	cas_char_t               gray_m2_ff;
	cas_char_t               scan_bin;
	cas_mode_t               mode_m1_ff;
	cas_mode_t               mode_m2_ff;
	logic                    ack_ff;
	cas_char_t               gray_ff;

	cas_fifo #(
		.W (`CAS_WQ_W),
		.D (`CAS_WQ_DEPTH)
	) u_wq (
		.i_clk       (i_mclk),
		.i_reset     (i_reset),
		.i_in_valid  (i_wr_valid),
		.o_in_ready  (o_wr_ready),
		.i_in_data   ({i_wr_addr, i_wr_data}),
		.o_out_valid (wq_valid),
		.i_out_ready (wq_ready),
		.o_out_data  (wq_data)
	);

	// Writes wait while a code word is handed to the scan side
	assign wq_ready = (req_ff == ack_m2_ff);
	assign wr_fire  = wq_valid && wq_ready;
	assign wr_addr  = wq_data[`CAS_WQ_ADDR_MSB:`CAS_WQ_ADDR_LSB];

	genvar gi;
	generate
		for (gi = 0; gi < `CAS_RAM_WORDS; gi++) begin : g_ram
			always_ff @(posedge i_mclk or posedge i_reset) begin
				if (i_reset) begin
					ram_ff[gi] <= `CAS_RAM_INIT;
				end else if (wr_fire && wr_addr == 7'(gi)) begin
					ram_ff[gi] <= wq_data[`CAS_RAM_DW-1:0];
				end
			end
		end
	endgenerate

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			gray_m1_ff <= 8'h00;
			gray_m2_ff <= 8'h00;
			mode_m1_ff <= CAS_M32;
			mode_m2_ff <= CAS_M32;
			ack_m1_ff  <= 1'b0;
			ack_m2_ff  <= 1'b0;
		end else begin
			gray_m1_ff <= gray_ff;
			gray_m2_ff <= gray_m1_ff;
			mode_m1_ff <= i_mode;
			mode_m2_ff <= mode_m1_ff;
			ack_m1_ff  <= ack_ff;
			ack_m2_ff  <= ack_m1_ff;
		end
	end

	// Prefetch the code of the character after the one being shifted
	assign scan_bin = gray2bin(gray_m2_ff);
	assign rd_addr  = addr_mask(scan_bin + 8'h01, mode_m2_ff);

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			rd_data_ff <= `CAS_RAM_INIT;
		end else if (!wr_fire) begin
			rd_data_ff <= ram_ff[rd_addr];
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			sent_ff <= `CAS_RAM_INIT;
			req_ff  <= 1'b0;
		end else if (wq_ready && !wr_fire && rd_data_ff != sent_ff) begin
			sent_ff <= rd_data_ff;
			req_ff  <= !req_ff;
		end
	end

	host_wins_a: assert property (@(posedge i_mclk) disable iff (i_reset)
		wr_fire |=> rd_data_ff == $past(rd_data_ff))
		else $error("scan read took the memory during a host write");

	ram_write_a: assert property (@(posedge i_mclk) disable iff (i_reset)
		wr_fire |=> ram_ff[$past(wr_addr)] == $past(wq_data[7:0]))
		else $error("host write not stored in character memory");

	// Link clock side: counters, decoder and display pins
	logic                    req_l1_ff;
	logic                    req_l2_ff;
	logic                    start_ff;
	logic [`CAS_RAM_DW-1:0]  pre_code_ff;
	logic [`CAS_RAM_DW-1:0]  cur_code_ff;
	cas_mode_t               mode_l1_ff;
	cas_mode_t               mode_l2_ff;
	logic [2:0]              row_ff;
	cas_char_t               char_ff;
	logic [2:0]              col_ff;
	logic                    init_ff;
	logic                    load_ff;
	logic                    gate_ff;
	logic                    data_ff;
	logic [`CAS_COLS-1:0]    col_drv_ff;
	logic [2:0]              nxt_row;
	cas_char_t               nxt_char;
	logic [2:0]              nxt_col;
	logic                    nxt_init;
	logic                    nxt_load;
	logic [`CAS_RAM_DW-1:0]  nxt_code;
	logic                    char_step;
	logic                    col_step;
	cas_glyph_t              cur_glyph;
	logic [`CAS_COLS-1:0]    row_cols;
	logic [2:0]              row_num;

	always_ff @(posedge i_lclk or posedge i_reset) begin
		if (i_reset) begin
			req_l1_ff  <= 1'b0;
			req_l2_ff  <= 1'b0;
			ack_ff     <= 1'b0;
			mode_l1_ff <= CAS_M32;
			mode_l2_ff <= CAS_M32;
		end else begin
			req_l1_ff  <= req_ff;
			req_l2_ff  <= req_l1_ff;
			ack_ff     <= req_l2_ff;
			mode_l1_ff <= i_mode;
			mode_l2_ff <= mode_l1_ff;
		end
	end

	// Word is stable while the request toggle is unanswered
	always_ff @(posedge i_lclk or posedge i_reset) begin
		if (i_reset) begin
			pre_code_ff <= `CAS_RAM_INIT;
		end else if (req_l2_ff != ack_ff) begin
			pre_code_ff <= sent_ff;
		end
	end

	assign char_step = (row_ff == `CAS_ROW_LAST);
	// First edge after reset stays on row 7 of character 0
	assign nxt_row   = start_ff ? 3'h0 : row_ff + 3'h1;
	assign nxt_char  = char_step ? char_ff + 8'h01 : char_ff;
	assign nxt_code  = char_step ? pre_code_ff : cur_code_ff;
	// First pass after reset is a load of every addressed character
	assign nxt_init  = init_ff &&
	                   !(char_step && addr_mask(nxt_char, mode_l2_ff) == 7'h0);
	assign nxt_load  = nxt_init || is_load(nxt_char, mode_l2_ff);
	// Column moves on as each regular load pass begins
	assign col_step  = char_step && !init_ff &&
	                   is_load(nxt_char, mode_l2_ff) &&
	                   !is_load(char_ff, mode_l2_ff);
	assign nxt_col   = !col_step ? col_ff :
	                   (col_ff == `CAS_COL_LAST) ? 3'h0 : col_ff + 3'h1;

	// Row count 0..6 presents rows 7..1
	assign row_num   = 3'h7 - nxt_row;
	assign cur_glyph = glyph(nxt_code[6:0]);
	assign row_cols  = (row_num == 3'h0) ? 5'h00 :
	                   cur_glyph[5'(row_num - 3'h1) * 6'h5 +: 5];

	always_ff @(posedge i_lclk or posedge i_reset) begin
		if (i_reset) begin
			row_ff   <= 3'h0;
			char_ff  <= 8'h00;
			gray_ff  <= 8'h00;
			start_ff <= 1'b1;
		end else begin
			row_ff   <= nxt_row;
			char_ff  <= nxt_char;
			gray_ff  <= nxt_char ^ (nxt_char >> 1);
			start_ff <= 1'b0;
		end
	end

	always_ff @(posedge i_lclk or posedge i_reset) begin
		if (i_reset) begin
			cur_code_ff <= `CAS_RAM_INIT;
		end else begin
			cur_code_ff <= nxt_code;
		end
	end

	always_ff @(posedge i_lclk or posedge i_reset) begin
		if (i_reset) begin
			col_ff  <= 3'h0;
			init_ff <= 1'b1;
		end else begin
			col_ff  <= nxt_col;
			init_ff <= nxt_init;
		end
	end

	// Mux the active column bit onto the serial data line
	always_ff @(posedge i_lclk or posedge i_reset) begin
		if (i_reset) begin
			data_ff <= 1'b0;
		end else begin
			data_ff <= row_cols[3'h4 - nxt_col];
		end
	end

	// Clock gate open for rows 7..1 of each character during load
	always_ff @(posedge i_lclk or posedge i_reset) begin
		if (i_reset) begin
			gate_ff <= 1'b0;
		end else begin
			gate_ff <= nxt_load && (nxt_row != `CAS_ROW_LAST);
		end
	end

	// In 32 mode seven of eight super-periods drive one column: 7/8 x 1/5
	always_ff @(posedge i_lclk or posedge i_reset) begin
		if (i_reset) begin
			load_ff    <= 1'b1;
			col_drv_ff <= 5'h00;
		end else begin
			load_ff    <= nxt_load;
			col_drv_ff <= nxt_load ? 5'h00 :
			              5'(`CAS_COL_FIRST << nxt_col);
		end
	end

	// Pulse sits in the low half so data is settled at its rise
	assign o_disp_clk  = gate_ff & ~i_lclk;
	assign o_disp_data = data_ff;
	assign o_blank     = load_ff;
	assign o_col_drv   = col_drv_ff;

	gate_run_a: assert property (@(posedge i_lclk) disable iff (i_reset)
		$rose(gate_ff) |-> gate_ff[*7] ##1 !gate_ff)
		else $error("display clock gate not open for seven cycles");

	row_wrap_a: assert property (@(posedge i_lclk) disable iff (i_reset)
		row_ff == 3'h7 |=> row_ff == 3'h0 &&
		char_ff == $past(char_ff) + 8'h01)
		else $error("character counter did not follow the row counter");

	blank_off_a: assert property (@(posedge i_lclk) disable iff (i_reset)
		o_blank |-> o_col_drv == 5'h00)
		else $error("column driver on during a load pass");

	col_onehot_a: assert property (@(posedge i_lclk) disable iff (i_reset)
		!o_blank |-> $onehot(o_col_drv) && !gate_ff)
		else $error("display phase without exactly one column");

	load32_a: assert property (@(posedge i_lclk) disable iff (i_reset)
		mode_l2_ff == CAS_M32 && char_ff[7:5] == 3'h7 |-> o_blank)
		else $error("32 mode missed its load pass");

	show32_a: assert property (@(posedge i_lclk) disable iff (i_reset)
		mode_l2_ff == CAS_M32 && char_ff[7:5] != 3'h7 && !init_ff
		|-> !o_blank)
		else $error("32 mode blanked outside the load pass");

	show64_a: assert property (@(posedge i_lclk) disable iff (i_reset)
		mode_l2_ff == CAS_M64 && char_ff[7:6] != 2'h3 && !init_ff
		|-> !o_blank)
		else $error("64 mode blanked outside the load pass");

	col_step_a: assert property (@(posedge i_lclk) disable iff (i_reset)
		$rose(o_blank) && !init_ff |-> col_ff ==
		(($past(col_ff) == 3'h4) ? 3'h0 : $past(col_ff) + 3'h1))
		else $error("column did not advance at the load pass");

endmodule : cas_scanner

// file: bench/cas_disp_model.sv
// Model of the cascaded serial-input dot-matrix display string
`timescale 1ns/100ps
module cas_disp_model (
	input  wire logic           i_reset,
	input  wire logic           i_disp_data,
	input  wire logic           i_disp_clk,
	input  wire logic           i_blank,
	output int                  o_pulses,
	output int                  o_stray,
	output logic [223:0]        o_sr
);
	// Rows shift in on each display clock rise, newest bit at the bottom
	always_ff @(posedge i_disp_clk or posedge i_reset) begin
		if (i_reset) begin
			o_sr     <= '0;
			o_pulses <= 0;
			o_stray  <= 0;
		end else begin
			o_sr     <= {o_sr[222:0], i_disp_data};
			o_pulses <= o_pulses + 1;
			if (i_blank !== 1'b1) begin
				o_stray <= o_stray + 1;
			end
		end
	end
endmodule : cas_disp_model

// file: bench/test_cas_scanner.sv
// Self-checking bench of the coded character display scanner
`timescale 1ns/100ps
module test_cas_scanner;
	import cas_pkg::*;
	// Inner columns of the hollow box glyph: top and bottom row lit
	localparam logic [6:0] BOX_INNER = 7'h41;
	logic               i_mclk;
	logic               i_reset;
	logic               i_lclk;
	cas_mode_t          i_mode;
	logic               i_wr_valid;
	logic [6:0]         i_wr_addr;
	logic [7:0]         i_wr_data;
	wire logic          o_wr_ready;
	wire logic          o_disp_data;
	wire logic          o_disp_clk;
	wire logic          o_blank;
	wire logic [4:0]    o_col_drv;
	int                 o_pulses;
	int                 o_stray;
	logic [223:0]       o_sr;
	int                 failures;
	int                 samples_checked;
	int                 seed;
	int                 n;
	int                 lo;
	int                 p0;
	logic [7:0]         codes [32];

	cas_scanner cas_scanner_i (
		.i_mclk      (i_mclk),
		.i_reset     (i_reset),
		.i_lclk      (i_lclk),
		.i_mode      (i_mode),
		.i_wr_valid  (i_wr_valid),
		.o_wr_ready  (o_wr_ready),
		.i_wr_addr   (i_wr_addr),
		.i_wr_data   (i_wr_data),
		.o_disp_data (o_disp_data),
		.o_disp_clk  (o_disp_clk),
		.o_blank     (o_blank),
		.o_col_drv   (o_col_drv)
	);

	cas_disp_model cas_disp_model_i (
		.i_reset     (i_reset),
		.i_disp_data (o_disp_data),
		.i_disp_clk  (o_disp_clk),
		.i_blank     (o_blank),
		.o_pulses    (o_pulses),
		.o_stray     (o_stray),
		.o_sr        (o_sr)
	);

	initial begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end

	// Link clock with an unrelated phase
	initial begin
		i_lclk = 1'b0;
		#37;
		forever #80 i_lclk = ~i_lclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Column 1 of the font, rows 7 down to 1
	function automatic logic [6:0] col1(input logic [7:0] c);
		return (c == 8'h7F) ? BOX_INNER : 7'h00;
	endfunction : col1

	task automatic test_done;
		$display("failures=%0d samples_checked=%0d", failures,
			samples_checked);
		if (failures == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done

	task automatic do_reset(input cas_mode_t m);
		@(posedge i_mclk);
		i_reset    <= 1'b1;
		i_mode     <= m;
		i_wr_valid <= 1'b0;
		repeat (5) @(posedge i_lclk);
		chk(o_blank, 1'b1);
		chk(o_col_drv, 5'h00);
		chk(o_wr_ready, 1'b1);
		chk(o_disp_clk, 1'b0);
		@(posedge i_mclk);
		i_reset <= 1'b0;
	endtask : do_reset

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic ok;
		@(posedge i_mclk);
		i_wr_valid <= 1'b1;
		i_wr_addr  <= a;
		i_wr_data  <= d;
		ok = 1'b0;
		for (int i = 0; i < 1000 && ok !== 1'b1; i++) begin
			@(negedge i_mclk);
			ok = o_wr_ready;
			@(posedge i_mclk);
		end
		i_wr_valid <= 1'b0;
		chk(ok, 1'b1);
	endtask : wr

	// Link cycles until the blank level leaves lvl
	task automatic phase_len(input logic lvl, output int len);
		len = 0;
		do begin
			@(posedge i_lclk);
			#1;
			len++;
		end while (o_blank === lvl && len < 3000);
	endtask : phase_len

	always @(negedge i_lclk) begin
		if (o_blank === 1'b1 && o_col_drv !== 5'h00) begin
			chk(o_col_drv, 5'h00);
		end
	end

	initial begin
		#1000000;
		failures++;
		test_done;
	end

	initial begin
		seed = 8;
		failures = 0;
		samples_checked = 0;
		i_reset = 1'b1;
		i_mode = CAS_M32;
		i_wr_valid = 1'b0;
		i_wr_addr = '0;
		i_wr_data = '0;
		do_reset(CAS_M32);
		for (int k = 0; k < 32; k++) begin
			case ($unsigned($random(seed)) % 3)
				0: codes[k] = 8'h20;
				1: codes[k] = 8'h7F;
				default: codes[k] = {3'h0, 5'($random(seed))};
			endcase
		end
		codes[0] = 8'h00;
		codes[3] = 8'h7F;
		codes[31] = 8'h7F;
		// Host writes land while the first load pass reads memory
		for (int k = 0; k < 32; k++) begin
			repeat ($unsigned($random(seed)) % 4) @(posedge i_mclk);
			wr(7'(k), codes[k]);
		end
		wr(7'h40, 8'h7F);
		phase_len(1'b1, n);
		chk(o_pulses, 224);
		chk(o_col_drv, 5'h01);
		p0 = o_pulses;
		// First display after the start-up load is 192 characters long
		phase_len(1'b0, lo);
		chk(lo, 1536);
		phase_len(1'b1, n);
		chk(n, 256);
		chk(o_pulses - p0, 224);
		chk(o_stray, 0);
		chk(o_col_drv, 5'h02);
		for (int k = 0; k < 32; k++) begin
			chk(o_sr[7*(31-k) +: 7], col1(codes[k]));
		end
		phase_len(1'b0, lo);
		chk(lo, 1792);
		chk(lo * 200, 175 * (lo + n));
		do_reset(CAS_M64);
		phase_len(1'b1, n);
		chk(o_pulses, 448);
		chk(o_stray, 0);
		repeat (8) @(posedge i_lclk);
		#1;
		chk(o_blank, 1'b0);
		chk(o_col_drv, 5'h01);
		do_reset(CAS_M128);
		repeat (100) @(posedge i_lclk);
		#1;
		chk(o_blank, 1'b1);
		chk(o_pulses >= 84 && o_pulses <= 91, 1'b1);
		test_done;
	end
endmodule : test_cas_scanner
